// ### host.sv
// Bus master model; the data line is open drain and pulled up in the bench.
`timescale 1ns/10ps
module host (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl = 1'b1,
	output logic o_sda = 1'b1
);
	task automatic s(input logic c, input logic d);
		o_scl <= c;
		o_sda <= d;
		repeat (5) @(posedge i_clk);
	endtask
	task automatic cond(input logic a, input logic z);
		s(1'b0, o_sda);
		s(1'b0, a);
		s(1'b1, a);
		s(1'b1, z);
	endtask
	task automatic b(input logic d, output logic q);
		s(1'b0, o_sda);
		s(1'b0, d);
		s(1'b1, d);
		s(1'b1, d);
		q = i_sda;
	endtask
	task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) b(w[i], r[i]);
		b(a, k);
	endtask
endmodule // host

// ### rtc_serial_pkg.sv
// Shared constants and carrier types for the two-wire slave port of the real-time clock.
package rtc_serial_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h68;
	localparam int REG_COUNT = 8;
	localparam logic [2:0] ADDR_SECONDS = 3'h0;
	localparam logic [2:0] ADDR_LAST_CLOCK = 3'h6;
	localparam logic [2:0] ADDR_CALIB = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SLAVE = 3'b001,
		ST_ACK_TX = 3'b010,
		ST_WORD = 3'b011,
		ST_DATA_RX = 3'b100,
		ST_DATA_TX = 3'b101,
		ST_ACK_RX = 3'b110
	} port_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} line_pair_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] data;
		logic strobe;
	} reg_write_t;
endpackage

// ### rtc_two_wire_slave_port.sv
// Two-wire slave port that gives a bus master access to seven clock registers and a calibration register.
`timescale 1ns/10ps
module rtc_two_wire_slave_port (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic [7:0] i_live_time [rtc_serial_pkg::REG_COUNT-1],
	input wire logic i_live_valid,
	output rtc_serial_pkg::reg_write_t o_wr,
	output logic o_time_reload,
	output logic o_update_hold,
	output logic [7:0] o_calib
);
	import rtc_serial_pkg::*;

	logic rst_meta;
	logic rst_n;
	line_pair_t sync1;
	line_pair_t sync2;
	line_pair_t prev;
	port_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [2:0] pointer;
	logic reading;
	logic rw_bit;
	logic [7:0] regs [REG_COUNT];
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic have_bits;
	logic acked;
	logic byte_done;
	logic [7:0] tx_byte;
	port_state_t ack_src;

	function automatic logic [2:0] next_addr(input logic [2:0] a);
		next_addr = (a == ADDR_CALIB) ? ADDR_SECONDS : a + 3'h1;
	endfunction

	function automatic logic is_rx_state(input port_state_t s);
		is_rx_state = (s == ST_SLAVE) || (s == ST_WORD) || (s == ST_DATA_RX);
	endfunction

	function automatic logic is_clock_addr(input logic [2:0] a);
		is_clock_addr = (a <= ADDR_LAST_CLOCK);
	endfunction

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Bus lines idle high; the first stage feeds only the second.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= '{scl: 1'b1, sda: 1'b1};
			sync2 <= '{scl: 1'b1, sda: 1'b1};
			prev <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			sync1 <= '{scl: i_scl, sda: i_sda};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	assign start_seen = prev.scl && sync2.scl && prev.sda && !sync2.sda;
	assign stop_seen = prev.scl && sync2.scl && !prev.sda && sync2.sda;
	assign scl_rise = !prev.scl && sync2.scl;
	assign scl_fall = prev.scl && !sync2.scl;

	// A byte is complete only once bits were shifted; the clock fall that ends a
	// start condition must not be taken for the end of a byte.
	assign byte_done = is_rx_state(state) && scl_fall && have_bits && bit_cnt == 3'h0;
	assign tx_byte = regs[pointer];

	// Transfer framing: start and stop override every state.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			ack_src <= ST_IDLE;
		end else if (stop_seen) begin
			state <= ST_IDLE;
		end else if (start_seen) begin
			state <= ST_SLAVE;
		end else begin
			unique case (state)
			ST_IDLE: begin
				state <= ST_IDLE;
			end
			ST_SLAVE: begin
				if (byte_done) begin
					if (shreg[7:1] != SLAVE_ADDR) begin
						state <= ST_IDLE;
					end else begin
						ack_src <= ST_SLAVE;
						state <= ST_ACK_TX;
					end
				end
			end
			ST_WORD, ST_DATA_RX: begin
				if (byte_done) begin
					ack_src <= state;
					state <= ST_ACK_TX;
				end
			end
			ST_ACK_TX: begin
				if (scl_fall) begin
					if (ack_src == ST_SLAVE && rw_bit) begin
						state <= ST_DATA_TX;
					end else if (ack_src == ST_SLAVE) begin
						state <= ST_WORD;
					end else begin
						state <= ST_DATA_RX;
					end
				end
			end
			ST_DATA_TX: begin
				if (scl_fall && bit_cnt == BIT_LAST) begin
					state <= ST_ACK_RX;
				end
			end
			ST_ACK_RX: begin
				if (scl_rise && sync2.sda) begin
					state <= ST_IDLE;
				end else if (scl_fall && acked) begin
					state <= ST_DATA_TX;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// Received bits shift in on the rising clock; sent bits shift out after each fall.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 3'h0;
			shreg <= BYTE_RESET;
			have_bits <= 1'b0;
		end else if (start_seen || stop_seen) begin
			bit_cnt <= 3'h0;
			have_bits <= 1'b0;
		end else if (is_rx_state(state)) begin
			if (scl_rise) begin
				shreg <= {shreg[6:0], sync2.sda};
				bit_cnt <= bit_cnt + 3'h1;
				have_bits <= 1'b1;
			end else if (byte_done) begin
				have_bits <= 1'b0;
			end
		end else if (state == ST_ACK_TX && scl_fall) begin
			bit_cnt <= 3'h0;
			shreg <= {tx_byte[6:0], 1'b0};
		end else if (state == ST_DATA_TX && scl_fall) begin
			bit_cnt <= bit_cnt + 3'h1;
			shreg <= {shreg[6:0], 1'b0};
		end else if (state == ST_ACK_RX && scl_fall && acked) begin
			bit_cnt <= 3'h0;
			shreg <= {tx_byte[6:0], 1'b0};
		end
	end

	// Data line drive; every change but the release at a start or stop follows a clock fall,
	// so apart from that release the line is quiet while the clock is high.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_sda_out <= 1'b1;
			o_sda_oe <= 1'b0;
		end else if (start_seen || stop_seen) begin
			o_sda_oe <= 1'b0;
		end else if (byte_done && (state != ST_SLAVE || shreg[7:1] == SLAVE_ADDR)) begin
			o_sda_out <= 1'b0;
			o_sda_oe <= 1'b1;
		end else if (state == ST_ACK_TX && scl_fall) begin
			o_sda_out <= tx_byte[BIT_LAST];
			o_sda_oe <= (ack_src == ST_SLAVE) && rw_bit;
		end else if (state == ST_DATA_TX && scl_fall) begin
			o_sda_out <= shreg[BIT_LAST];
			o_sda_oe <= (bit_cnt != BIT_LAST);
		end else if (state == ST_ACK_RX && scl_fall && acked) begin
			o_sda_out <= tx_byte[BIT_LAST];
			o_sda_oe <= 1'b1;
		end
	end

	// Only the low bits of the word address select one of the eight locations.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer <= ADDR_SECONDS;
		end else if (state == ST_WORD && byte_done) begin
			pointer <= shreg[2:0];
		end else if (state == ST_ACK_TX && scl_fall && ack_src == ST_DATA_RX) begin
			pointer <= next_addr(pointer);
		end else if (state == ST_ACK_RX && scl_rise && !sync2.sda) begin
			pointer <= next_addr(pointer);
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rw_bit <= 1'b0;
		end else if (state == ST_SLAVE && byte_done) begin
			rw_bit <= shreg[0];
		end
	end

	// The freeze starts as soon as a read is addressed at a clock register, or at the acknowledge that steps onto one, before its first bit leaves.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			reading <= 1'b0;
		end else if (start_seen || stop_seen) begin
			reading <= 1'b0;
		end else if (state == ST_SLAVE && byte_done && shreg == {SLAVE_ADDR, 1'b1}) begin
			reading <= is_clock_addr(pointer);
		end else if (state == ST_ACK_RX && scl_rise) begin
			reading <= !sync2.sda && is_clock_addr(next_addr(pointer));
		end
	end

	// Keeps a master acknowledge until its clock pulse falls.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			acked <= 1'b0;
		end else if (state != ST_ACK_RX || start_seen || stop_seen) begin
			acked <= 1'b0;
		end else if (scl_rise) begin
			acked <= !sync2.sda;
		end
	end

	assign o_calib = regs[ADDR_CALIB];

	logic wr_fire;
	assign wr_fire = (state == ST_DATA_RX) && byte_done;

	// Write path: store the byte at the eighth clock fall; advance the pointer when the acknowledge clock falls.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_wr <= '0;
			o_time_reload <= 1'b0;
		end else begin
			o_wr.strobe <= wr_fire;
			o_wr.addr <= pointer;
			o_wr.data <= shreg;
			o_time_reload <= wr_fire && is_clock_addr(pointer);
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_update_hold <= 1'b0;
		end else begin
			o_update_hold <= reading && !stop_seen;
		end
	end

	// Register image: writes land here, live counts refresh clock slots unless frozen.
	genvar g;
	generate
		for (g = 0; g < REG_COUNT; g++) begin : g_reg
			if (g < REG_COUNT - 1) begin : g_clock
				always_ff @(posedge i_clk or negedge rst_n) begin
					if (!rst_n) begin
						regs[g] <= BYTE_RESET;
					end else if (wr_fire && pointer == 3'(g)) begin
						regs[g] <= shreg;
					end else if (i_live_valid && !reading) begin
						regs[g] <= i_live_time[g];
					end
				end
			end else begin : g_calib
				always_ff @(posedge i_clk or negedge rst_n) begin
					if (!rst_n) begin
						regs[g] <= BYTE_RESET;
					end else if (wr_fire && pointer == 3'(g)) begin
						regs[g] <= shreg;
					end
				end
			end
		end
	endgenerate
endmodule // rtc_two_wire_slave_port

// ### rtc_two_wire_slave_port_monitor.sv
// Checker on the slave port pins.
`timescale 1ns/10ps
module rtc_two_wire_slave_port_monitor
	import rtc_serial_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_oe,
	input wire rtc_serial_pkg::reg_write_t o_wr,
	input wire logic o_time_reload,
	input wire logic o_update_hold
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence start_seen; i_scl && $fell(i_sda); endsequence
	sequence stop_seen; i_scl && $rose(i_sda); endsequence
	strobe_once_a: assert property (o_wr.strobe |=> !o_wr.strobe) else $error("strobe held");
	reload_once_a: assert property (o_time_reload |=> !o_time_reload) else $error("reload held");
	reload_addr_a: assert property (o_wr.strobe |->
		o_time_reload == (o_wr.addr <= ADDR_LAST_CLOCK)) else $error("reload wrong");
	oe_quiet_a: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("oe moved");
	oe_stand_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8]) else $error("oe short");
	hold_stop_a: assert property (stop_seen |-> ##[1:8] !o_update_hold) else $error("hold");
	start_free_a: assert property (start_seen |-> !o_sda_oe [*8]) else $error("oe at start");
	reload_free_a: assert property (o_time_reload |-> !o_update_hold) else $error("reload");
endmodule // rtc_two_wire_slave_port_monitor
bind rtc_two_wire_slave_port rtc_two_wire_slave_port_monitor monitor_inst (.i_clk, .i_rst_n,
	.i_scl, .i_sda, .o_sda_oe, .o_wr, .o_time_reload, .o_update_hold);

// ### rtc_two_wire_slave_port_tb.sv
// Bench for the two-wire slave port.
`timescale 1ns/10ps
module rtc_two_wire_slave_port_tb;
	import rtc_serial_pkg::*;
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_live_valid = 1'b0;
	logic [7:0] i_live_time [REG_COUNT-1];
	logic o_sda_out, o_sda_oe, o_time_reload, o_update_hold, scl, msda, k;
	logic [7:0] o_calib, r, c, s = 8'h57;
	reg_write_t o_wr, w;
	int errors = 0, comparisons = 0;
	wire sda = msda & ~(o_sda_oe & ~o_sda_out);
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_wr.strobe === 1'b1) w <= o_wr;
	rtc_two_wire_slave_port rtc_two_wire_slave_port_inst (.i_clk, .i_rst_n, .i_scl(scl),
		.i_sda(sda), .o_sda_out, .o_sda_oe, .i_live_time, .i_live_valid, .o_wr,
		.o_time_reload, .o_update_hold, .o_calib);
	host host_inst (.i_clk, .i_sda(sda), .o_scl(scl), .o_sda(msda));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [7:0] v);
		host_inst.xfer(v, 1'b1, r, k);
		chk(11'(k), 11'h0);
	endtask
	task final_report;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < REG_COUNT - 1; i++) i_live_time[i] <= lfsr(s ^ 8'(i));
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		i_live_valid <= 1'b1;
		repeat (6) @(posedge i_clk);
		host_inst.cond(1'b1, 1'b0);
		host_inst.xfer(8'hd2, 1'b1, r, k);
		chk(11'(k), 11'h1);
		host_inst.cond(1'b0, 1'b1);
		host_inst.cond(1'b1, 1'b0);
		wb({SLAVE_ADDR, 1'b0});
		wb({5'h0, ADDR_CALIB});
		c = lfsr(s);
		for (int i = 0; i < 3; i++) begin
			s = lfsr(s);
			wb(s);
			chk({w.addr, w.data}, {3'(ADDR_CALIB + i), s});
		end
		host_inst.cond(1'b0, 1'b1);
		chk(11'(o_calib), 11'(c));
		host_inst.cond(1'b1, 1'b0);
		wb({SLAVE_ADDR, 1'b0});
		wb({5'h0, ADDR_LAST_CLOCK});
		host_inst.cond(1'b1, 1'b0);
		wb({SLAVE_ADDR, 1'b1});
		chk(11'(o_update_hold), 11'h1);
		host_inst.xfer(8'hff, 1'b0, r, k);
		chk(11'(r), 11'(i_live_time[6]));
		host_inst.xfer(8'hff, 1'b1, r, k);
		chk(11'({o_update_hold, r}), 11'(c));
		host_inst.cond(1'b0, 1'b1);
		host_inst.cond(1'b1, 1'b0);
		wb({SLAVE_ADDR, 1'b1});
		host_inst.xfer(8'hff, 1'b1, r, k);
		chk(11'(r), 11'(c));
		host_inst.cond(1'b0, 1'b1);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		errors++;
		final_report();
	end
endmodule // rtc_two_wire_slave_port_tb
